// ### sgl_pkg.sv
/*
  Shared definitions for the status group event logic: register bus
  carrier, register offsets, reset values, field positions and helpers.
  Assumes a single 100 MHz clock domain and 32-bit register data.
*/
`default_nettype none

package sgl_pkg;

  localparam int unsigned GRP_W  = 16;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned STB_W  = 8;
  localparam int unsigned IRQ_W  = 2;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_COND   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_PTR    = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_NTR    = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_EVENT  = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_ENABLE = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_ISTAT  = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_IMASK  = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_SRE    = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_STB    = 8'h24;

  // usable bits of a group; top bit always zero
  localparam logic [GRP_W-1:0] GRP_MASK   = 16'h7FFF;
  localparam logic [GRP_W-1:0] PTR_RST    = 16'h7FFF;
  localparam logic [GRP_W-1:0] NTR_RST    = 16'h0000;
  localparam logic [GRP_W-1:0] ENABLE_RST = 16'h0000;
  localparam logic [GRP_W-1:0] GRP_ZERO   = 16'h0000;

  // control register write bits
  localparam int unsigned CTRL_CLS_BIT    = 0;
  localparam int unsigned CTRL_PRESET_BIT = 1;

  // interrupt status bits
  localparam int unsigned IRQ_EVENT_BIT = 0;
  localparam int unsigned IRQ_SUMUP_BIT = 1;
  localparam logic [IRQ_W-1:0] IRQ_RST  = 2'h0;

  // status byte layout
  localparam int unsigned STB_GROUP_BIT = 7;
  localparam int unsigned STB_RQS_BIT   = 6;
  localparam logic [STB_W-1:0] SRE_RST  = 8'h00;
  localparam logic [STB_W-1:0] RQS_MASK = 8'hBF;

  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } sgl_bus_req_type;

  // access at one register offset
  function automatic logic sgl_hit(input logic [ADDR_W-1:0] addr,
                                   input logic              strobe,
                                   input logic [ADDR_W-1:0] ofs);
    sgl_hit = strobe && (addr == ofs);
  endfunction : sgl_hit

endpackage : sgl_pkg

`default_nettype wire

// ### sgl_edge_filter.sv
/*
  Transition filter of one status group: flags the bit positions whose
  condition change is selected by the positive and negative filters.
  Assumes current and previous condition are sampled on the same clock.
*/
`default_nettype none

module sgl_edge_filter (
  // condition now and one cycle ago
  input  wire  logic [15:0] cond_now_i,
  input  wire  logic [15:0] cond_prev_i,
  // filter settings
  input  wire  logic [15:0] ptr_i,
  input  wire  logic [15:0] ntr_i,
  // positions with a selected change
  output logic       [15:0] hit_o
);

  assign hit_o = (cond_now_i & ~cond_prev_i & ptr_i)
               | (~cond_now_i & cond_prev_i & ntr_i);

endmodule : sgl_edge_filter

`default_nettype wire

// ### sgl_status_group.sv
/*
  One status group: condition, positive and negative transition
  filters, latching event register, enable register, summary bit,
  a status byte with service request, and a level interrupt.
  Assumes synchronous inputs and a bus master with one-cycle strobes.
*/
// The placing of the registers and the plain strobed port were chosen for this implementation.
`default_nettype none

module sgl_status_group (
  // clock and reset
  input  wire  logic                    clock_i,
  input  wire  logic                    rst_n_i,
  // register port
  input  wire  sgl_pkg::sgl_bus_req_type bus_i,
  output logic [31:0]                   rdata_o,
  // monitored condition sources
  input  wire  logic [15:0]             cond_i,
  // other status byte summary sources
  input  wire  logic [7:0]              stb_src_i,
  // results
  output logic                          summary_o,
  output logic                          srq_o,
  output logic                          irq_o
);

  logic [15:0] cond_r;
  logic [15:0] cond_nxt;
  logic [15:0] ptr_r;
  logic [15:0] ntr_r;
  logic [15:0] event_r;
  logic [15:0] event_nxt;
  logic [15:0] enable_r;
  logic [15:0] hit;
  logic [1:0]  istat_r;
  logic [1:0]  istat_nxt;
  logic [1:0]  imask_r;
  logic [1:0]  imask_nxt;
  logic [7:0]  sre_r;
  logic [7:0]  sre_nxt;
  logic [7:0]  stb_nxt;
  logic        summary_nxt;
  logic        srq_nxt;
  logic        clr_stat;
  logic        preset;
  logic        wr_ptr;
  logic        wr_ntr;
  logic        wr_enable;
  logic        rd_event;
  logic        rd_istat;
  logic [31:0] rdata_nxt;

  // strobe decode
  always_comb
  begin
    clr_stat  = sgl_pkg::sgl_hit(bus_i.addr, bus_i.wr, sgl_pkg::OFS_CTRL)
                && bus_i.wdata[sgl_pkg::CTRL_CLS_BIT];
    preset    = sgl_pkg::sgl_hit(bus_i.addr, bus_i.wr, sgl_pkg::OFS_CTRL)
                && bus_i.wdata[sgl_pkg::CTRL_PRESET_BIT];
    wr_ptr    = sgl_pkg::sgl_hit(bus_i.addr, bus_i.wr, sgl_pkg::OFS_PTR);
    wr_ntr    = sgl_pkg::sgl_hit(bus_i.addr, bus_i.wr, sgl_pkg::OFS_NTR);
    wr_enable = sgl_pkg::sgl_hit(bus_i.addr, bus_i.wr,
                                 sgl_pkg::OFS_ENABLE);
    rd_event  = sgl_pkg::sgl_hit(bus_i.addr, bus_i.rd, sgl_pkg::OFS_EVENT);
    rd_istat  = sgl_pkg::sgl_hit(bus_i.addr, bus_i.rd, sgl_pkg::OFS_ISTAT);
  end

  // condition sampled each cycle, bus has no path into it
  assign cond_nxt = cond_i & sgl_pkg::GRP_MASK;

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
      cond_r <= sgl_pkg::GRP_ZERO;
    else
      cond_r <= cond_nxt;
  end

  // filters: only bus writes and preset touch them
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      ptr_r <= sgl_pkg::PTR_RST;
      ntr_r <= sgl_pkg::NTR_RST;
    end
    else if (preset)
    begin
      ptr_r <= sgl_pkg::GRP_MASK;
      ntr_r <= sgl_pkg::GRP_ZERO;
    end
    else
    begin
      if (wr_ptr)
        ptr_r <= bus_i.wdata[15:0] & sgl_pkg::GRP_MASK;
      if (wr_ntr)
        ntr_r <= bus_i.wdata[15:0] & sgl_pkg::GRP_MASK;
    end
  end

  // next and registered condition plus both filter registers feed one filter instance
  sgl_edge_filter u_edge_filter (
    .cond_now_i  (cond_nxt),
    .cond_prev_i (cond_r),
    .ptr_i       (ptr_r),
    .ntr_i       (ntr_r),
    .hit_o       (hit)
  );

  // event latch: a new hit wins over a clear
  assign event_nxt = ((rd_event || clr_stat) ? sgl_pkg::GRP_ZERO
                                             : event_r)
                     | (hit & sgl_pkg::GRP_MASK);

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
      event_r <= sgl_pkg::GRP_ZERO;
    else
      event_r <= event_nxt;
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
      enable_r <= sgl_pkg::ENABLE_RST;
    else if (wr_enable)
      enable_r <= bus_i.wdata[15:0] & sgl_pkg::GRP_MASK;
  end

  // summary from next values so it moves with the registers
  always_comb
  begin
    summary_nxt = |(event_nxt &
                    (wr_enable ? bus_i.wdata[15:0] & sgl_pkg::GRP_MASK
                               : enable_r));
    stb_nxt = stb_src_i & sgl_pkg::RQS_MASK;
    stb_nxt[sgl_pkg::STB_GROUP_BIT] = summary_nxt;
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
      summary_o <= 1'b0;
    else
      summary_o <= summary_nxt;
  end

  // service request enable mask; request follows a mask write at once
  assign sre_nxt = sgl_pkg::sgl_hit(bus_i.addr, bus_i.wr, sgl_pkg::OFS_SRE)
                   ? bus_i.wdata[7:0] & sgl_pkg::RQS_MASK
                   : sre_r;

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
      sre_r <= sgl_pkg::SRE_RST;
    else
      sre_r <= sre_nxt;
  end

  assign srq_nxt = |(stb_nxt & sre_nxt);

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
      srq_o <= 1'b0;
    else
      srq_o <= srq_nxt;
  end

  // sticky interrupt status, read clears, set wins
  always_comb
  begin
    istat_nxt = rd_istat ? sgl_pkg::IRQ_RST : istat_r;
    if (|hit)
      istat_nxt[sgl_pkg::IRQ_EVENT_BIT] = 1'b1;
    if (summary_nxt && !summary_o)
      istat_nxt[sgl_pkg::IRQ_SUMUP_BIT] = 1'b1;
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
      istat_r <= sgl_pkg::IRQ_RST;
    else
      istat_r <= istat_nxt;
  end

  // interrupt follows a mask write in the same cycle
  assign imask_nxt =
    sgl_pkg::sgl_hit(bus_i.addr, bus_i.wr, sgl_pkg::OFS_IMASK)
    ? bus_i.wdata[1:0] : imask_r;

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
      imask_r <= sgl_pkg::IRQ_RST;
    else
      imask_r <= imask_nxt;
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
      irq_o <= 1'b0;
    else
      irq_o <= |(istat_nxt & imask_nxt);
  end

  // read mux; unmapped offsets read zero
  always_comb
  begin
    rdata_nxt = sgl_pkg::DATA_ZERO;
    if (bus_i.rd)
    begin
      case (bus_i.addr)
        sgl_pkg::OFS_COND:   rdata_nxt[15:0] = cond_r;
        sgl_pkg::OFS_PTR:    rdata_nxt[15:0] = ptr_r;
        sgl_pkg::OFS_NTR:    rdata_nxt[15:0] = ntr_r;
        sgl_pkg::OFS_EVENT:  rdata_nxt[15:0] = event_r;
        sgl_pkg::OFS_ENABLE: rdata_nxt[15:0] = enable_r;
        sgl_pkg::OFS_ISTAT:  rdata_nxt[1:0]  = istat_r;
        sgl_pkg::OFS_IMASK:  rdata_nxt[1:0]  = imask_r;
        sgl_pkg::OFS_SRE:    rdata_nxt[7:0]  = sre_r;
        sgl_pkg::OFS_STB:
        begin
          rdata_nxt[7:0] = stb_src_i & sgl_pkg::RQS_MASK;
          rdata_nxt[sgl_pkg::STB_GROUP_BIT] = summary_o;
          rdata_nxt[sgl_pkg::STB_RQS_BIT]   = srq_o;
        end
        default:             rdata_nxt = sgl_pkg::DATA_ZERO;
      endcase
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
      rdata_o <= sgl_pkg::DATA_ZERO;
    else
      rdata_o <= rdata_nxt;
  end

  // checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  a_cond_read_live: assert property (
    sgl_pkg::sgl_hit(bus_i.addr, bus_i.rd, sgl_pkg::OFS_COND)
    |=> rdata_o[15:0] == ($past(cond_i, 2) & sgl_pkg::GRP_MASK))
    else $error("condition read does not show live input");

  a_cond_no_write: assert property (
    sgl_pkg::sgl_hit(bus_i.addr, bus_i.wr, sgl_pkg::OFS_COND)
    |=> cond_r == ($past(cond_i) & sgl_pkg::GRP_MASK))
    else $error("write changed condition register");

  a_hit_sets_event: assert property (
    (|((cond_nxt & ~cond_r & ptr_r) | (~cond_nxt & cond_r & ntr_r)))
    |=> (event_r & $past((cond_nxt & ~cond_r & ptr_r)
                         | (~cond_nxt & cond_r & ntr_r)))
        == $past((cond_nxt & ~cond_r & ptr_r)
                 | (~cond_nxt & cond_r & ntr_r)))
    else $error("selected transition did not set event bit");

  a_filter_kept: assert property (
    (clr_stat || bus_i.rd) && !preset && !wr_ptr && !wr_ntr
    |=> $stable(ptr_r) && $stable(ntr_r))
    else $error("filter changed on clear or query");

  a_preset_filters: assert property (
    preset |=> ptr_r == sgl_pkg::GRP_MASK && ntr_r == sgl_pkg::GRP_ZERO)
    else $error("preset left filters wrong");

  a_event_sticky: assert property (
    !rd_event && !clr_stat |=> (event_r & $past(event_r)) == $past(event_r))
    else $error("event bit dropped without clear");

  a_event_clear: assert property (
    (rd_event || clr_stat) && hit == sgl_pkg::GRP_ZERO
    |=> event_r == sgl_pkg::GRP_ZERO)
    else $error("event register not cleared");

  a_event_no_write: assert property (
    sgl_pkg::sgl_hit(bus_i.addr, bus_i.wr, sgl_pkg::OFS_EVENT)
    && !clr_stat && hit == sgl_pkg::GRP_ZERO |=> $stable(event_r))
    else $error("write changed event register");

  a_summary_tie: assert property (
    summary_o == |(event_r & enable_r))
    else $error("summary does not match event and enable");

  a_enable_read: assert property (
    sgl_pkg::sgl_hit(bus_i.addr, bus_i.rd, sgl_pkg::OFS_ENABLE)
    |=> $stable(enable_r) && rdata_o[15:0] == $past(enable_r))
    else $error("enable read wrong or disturbing");

  a_top_bit_zero: assert property (
    !event_r[15] && !ptr_r[15] && !ntr_r[15] && !enable_r[15]
    && !cond_r[15])
    else $error("unused top bit set");

  a_srq_level: assert property (
    srq_o == |(({summary_o, 7'h00} | ($past(stb_src_i) & 8'h3F)) & sre_r))
    else $error("service request disagrees with status byte");

  c_event_set:  cover property (|hit ##1 summary_o);
  c_read_clear: cover property (rd_event && event_r != sgl_pkg::GRP_ZERO);
  c_preset:     cover property (preset ##1 |hit);
  c_srq_irq:    cover property (srq_o && irq_o);

endmodule : sgl_status_group

`default_nettype wire

// ### sgl_ctl_model.sv
/*
  Remote controller model: issues status commands and queries as
  register writes and reads. Assumes the block's one-cycle strobes
  and read data in the cycle after the read.
*/
`default_nettype none

module sgl_ctl_model (
  // clock
  input  wire logic                     clock_i,
  // register requests
  output var  sgl_pkg::sgl_bus_req_type bus_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial bus_o = '0;

  // one write or read; released bus shows inverted address and data
  task automatic xfer(input logic [7:0]  a,
                      input logic [31:0] d,
                      input logic        w);
    @(posedge clock_i);
    bus_o <= {a, d, w, ~w};
    @(posedge clock_i);
    bus_o <= {~a, ~d, 2'b00};
  endtask : xfer

endmodule : sgl_ctl_model

`default_nettype wire

// ### tb.sv
/*
  Self-checking bench for one status group: a cycle model of the
  registers is compared with the outputs at every clock edge.
  Assumes the controller model drives the register port.
*/
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;

`define CHK(got, exp) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) \
    begin \
      error_cnt++; \
      $display("FAIL %0t got %0h expected %0h", $time, got, exp); \
    end \
  end

  logic                     clock_i;
  logic                     rst_n_i;
  logic [15:0]              cond_i;
  logic [7:0]               stb_src_i;
  logic [31:0]              rdata_o;
  logic                     summary_o;
  logic                     srq_o;
  logic                     irq_o;
  sgl_pkg::sgl_bus_req_type bus;
  int                       error_cnt;
  int                       cmp_count;
  int                       cyc;
  logic [31:0]              seed = 32'h8F31;
  logic [31:0]              r;
  int prev, ptr, ntr, ev, en, ist, imask, sre, hit, c, rexp;
  logic s_m, i_m, q_m, old, pend, armed;

  sgl_ctl_model ctl (.clock_i(clock_i), .bus_o(bus));

  sgl_status_group dut (
    .clock_i  (clock_i),
    .rst_n_i  (rst_n_i),
    .bus_i    (bus),
    .rdata_o  (rdata_o),
    .cond_i   (cond_i),
    .stb_src_i(stb_src_i),
    .summary_o(summary_o),
    .srq_o    (srq_o),
    .irq_o    (irq_o)
  );

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  function automatic int rd_val(input logic [7:0] a);
    case (a)
      8'h00: return prev;
      8'h04: return ptr;
      8'h08: return ntr;
      8'h0C: return ev;
      8'h10: return en;
      8'h18: return ist;
      8'h1C: return imask;
      8'h20: return sre;
      8'h24: return int'({s_m, q_m, stb_src_i[5:0]});
      default: return 0;
    endcase
  endfunction : rd_val

  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test

  initial
  begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  // cycle model, compared on pre-edge values
  always @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      {prev, ntr, ev, en, ist, imask, sre} = 224'h0;
      ptr = 'h7FFF;
      {s_m, i_m, q_m, pend, armed} = 5'h01;
    end
    else if (armed)
    begin
      `CHK(summary_o, s_m)
      `CHK(irq_o, i_m)
      `CHK(srq_o, q_m)
      if (pend)
        `CHK(rdata_o, rexp)
      else
        `CHK(rdata_o, 32'h0000_0000)
      pend = bus.rd;
      rexp = rd_val(bus.addr);
      c = int'(cond_i);
      hit = (~prev & c & ptr | prev & ~c & ntr) & 'h7FFF;
      if (bus.rd && bus.addr == 8'h0C || bus.wr && bus.addr == 8'h14
          && bus.wdata[0])
        ev = 0;
      ev |= hit;
      if (bus.wr)
        case (bus.addr)
          8'h04: ptr = bus.wdata & 'h7FFF;
          8'h08: ntr = bus.wdata & 'h7FFF;
          8'h10: en = bus.wdata & 'h7FFF;
          8'h1C: imask = bus.wdata & 'h3;
          8'h20: sre = bus.wdata & 'hBF;
          8'h14: if (bus.wdata[1]) {ptr, ntr} = {32'h7FFF, 32'h0};
          default: ;
        endcase
      old = s_m;
      s_m = (ev & en) != 0;
      if (bus.rd && bus.addr == 8'h18)
        ist = 0;
      ist |= ((s_m && !old) ? 2 : 0) | ((hit != 0) ? 1 : 0);
      i_m = (ist & imask) != 0;
      q_m = (int'({s_m, 1'b0, stb_src_i[5:0]}) & sre) != 0;
      prev = c & 'h7FFF;
    end
  end

  always @(posedge clock_i)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      error_cnt++;
      finish_test();
    end
  end

  initial
  begin
    rst_n_i = 1'b0;
    cond_i = 16'h0000;
    stb_src_i = 8'h00;
    repeat (8) @(posedge clock_i);
    rst_n_i <= 1'b1;
    for (int a = 0; a <= 32; a += 4)
      ctl.xfer(8'(a), 32'h0000_0000, 1'b0);
    for (int a = 0; a <= 60; a += 4)
    begin
      ctl.xfer(8'(a), 32'hFFFF_FFFF, 1'b1);
      ctl.xfer(8'(a), 32'h0000_0000, 1'b0);
    end
    $display("test register map done");
    repeat (400)
    begin
      r = xs();
      cond_i <= r[15:0];
      stb_src_i <= r[23:16];
      r = xs();
      ctl.xfer(8'((r % 10) * 4), xs(), r[8]);
    end
    $display("test random traffic done");
    finish_test();
  end

`undef CHK

endmodule : tb

`default_nettype wire
